// [hw/isa_cyc_pkg.sv]
`default_nettype none
package isa_cyc_pkg;

  // ****************************************************************
  // system clock and isa timing clock (T)
  // ****************************************************************
  localparam int CLK_SYS_NS  = 25;
  // period of T per slave width; a least time, so it rounds up
  localparam int T_8BIT_NS   = 125;
  localparam int T_16BIT_NS  = 125;
  localparam int T_8BIT_CYC  = (T_8BIT_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
  localparam int T_16BIT_CYC = (T_16BIT_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;

  localparam logic [3:0] DIV_8BIT  = T_8BIT_CYC[3:0];
  localparam logic [3:0] DIV_16BIT = T_16BIT_CYC[3:0];

  // ****************************************************************
  // spacings in T, all lower bounds
  // ****************************************************************
  localparam int LA_TO_CMD_T   = 5;
  localparam int ALE_TO_CMD_T  = 2;
  localparam int ALE_PULSE_T   = 1;
  localparam int CMD_ACTIVE_T  = 9;
  localparam int LA_HOLD_CMD_T = 13;

  localparam logic [3:0] SETUP_T  = 4'(LA_TO_CMD_T - ALE_TO_CMD_T);
  localparam logic [3:0] ALE_T    = 4'(ALE_PULSE_T);
  localparam logic [3:0] GAP_T    = 4'(ALE_TO_CMD_T - ALE_PULSE_T);
  localparam logic [3:0] CMD_T    = 4'(CMD_ACTIVE_T);
  localparam logic [3:0] HOLD_T   = 4'(LA_HOLD_CMD_T - CMD_ACTIVE_T);

  // ****************************************************************
  // reset values and address split
  // ****************************************************************
  localparam logic [6:0]  LA_RST   = 7'h00;
  localparam logic [19:0] SA_RST   = 20'h00000;
  localparam logic [3:0]  LOW_MEG  = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SYNC,
    ST_SETUP,
    ST_ALE,
    ST_GAP,
    ST_CMD,
    ST_HOLD
  } seq_state_e;

endpackage : isa_cyc_pkg
`default_nettype wire

// [hw/isa_tick_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface isa_tick_if;
  logic tick;
  logic wide;
  modport gen (output tick, input wide);
  modport seq (input tick, output wide);
endinterface : isa_tick_if
`default_nettype wire

// [hw/isa_tick_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module isa_tick_gen
  import isa_cyc_pkg::*;
(
  // clock and reset
  input  wire logic   clk_sys_i,
  input  wire logic   rstn_i,
  // tick towards the sequencer
  isa_tick_if.gen     tk
);

  logic [3:0] div_cnt_ff;
  logic [3:0] nxt_div_cnt;
  logic       tick_ff;
  wire        wrap = (div_cnt_ff == 4'h0);
  wire  [3:0] div_sel = tk.wide ? DIV_16BIT : DIV_8BIT;

  // divisor change only takes effect at a wrap, so no T is ever cut short
  assign nxt_div_cnt = wrap ? (div_sel - 4'h1) : (div_cnt_ff - 4'h1);
  assign tk.tick     = tick_ff;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      div_cnt_ff <= 4'h0;
      tick_ff    <= 1'b0;
    end
    else
    begin
      div_cnt_ff <= nxt_div_cnt;
      tick_ff    <= wrap;
    end
  end

endmodule : isa_tick_gen
`default_nettype wire

// [hw/isa_master_cycle_timing.sv]
`timescale 1ns/1ps
`default_nettype none
module isa_master_cycle_timing
  import isa_cyc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  // cycle request
  input  wire logic        req_valid_i,
  input  wire logic        req_write_i,
  input  wire logic        req_io_i,
  input  wire logic        req_wide_i,
  input  wire logic [23:0] req_addr_i,
  input  wire logic        req_sbhe_n_i,
  output var  logic        req_ready_o,
  output var  logic        done_o,
  // slave ready pin
  input  wire logic        iochrdy_i,
  // bus pins
  output var  logic        ale_n_o,
  output var  logic [6:0]  la_o,
  output var  logic [19:0] sa_o,
  output var  logic        sbhe_n_o,
  output var  logic        memr_n_o,
  output var  logic        memw_n_o,
  output var  logic        smemr_n_o,
  output var  logic        smemw_n_o,
  output var  logic        ior_n_o,
  output var  logic        iow_n_o
);

  // ****************************************************************
  // strobe decode
  // ****************************************************************
  // returns {memr, memw, smemr, smemw, ior, iow}, active high
  function automatic logic [5:0] strobe_vec(
    input logic on,
    input logic io,
    input logic wr,
    input logic low
  );
    logic mem;
    mem = on & ~io;
    strobe_vec = {mem & ~wr, mem & wr, mem & low & ~wr, mem & low & wr, on & io & ~wr, on & io & wr};
  endfunction : strobe_vec

  // ****************************************************************
  // timing clock
  // ****************************************************************
  isa_tick_if u_tk ();

  logic cyc_wide_ff;

  assign u_tk.wide = cyc_wide_ff;

  isa_tick_gen u_tick_gen (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .tk        (u_tk)
  );

  // ****************************************************************
  // slave ready synchroniser
  // ****************************************************************
  logic rdy_meta_ff;
  logic rdy_sync_ff;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      rdy_meta_ff <= 1'b1;
      rdy_sync_ff <= 1'b1;
    end
    else
    begin
      rdy_meta_ff <= iochrdy_i;
      rdy_sync_ff <= rdy_meta_ff;
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  seq_state_e  state_ff;
  seq_state_e  nxt_state;
  logic [3:0]  cnt_ff;
  logic [3:0]  nxt_cnt;
  logic        cyc_io_ff;
  logic        cyc_wr_ff;
  logic        cyc_low_ff;

  wire         tick   = u_tk.tick;
  wire         take   = req_valid_i & req_ready_o;
  wire         expire = tick & (cnt_ff == 4'h0);

  always_comb
  begin
    nxt_state = state_ff;
    // one count per T, never per system clock
    nxt_cnt   = (tick && cnt_ff != 4'h0) ? (cnt_ff - 4'h1) : cnt_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (take)
        begin
          nxt_state = ST_SYNC;
        end
      end
      ST_SYNC:
      begin
        // start on a T boundary so every phase is whole periods
        if (tick)
        begin
          nxt_state = ST_SETUP;
          nxt_cnt   = SETUP_T - 4'h1;
        end
      end
      ST_SETUP:
      begin
        // addresses lead the latch by SETUP_T, the strobe by 5T
        if (expire)
        begin
          nxt_state = ST_ALE;
          nxt_cnt   = ALE_T - 4'h1;
        end
      end
      ST_ALE:
      begin
        if (expire)
        begin
          nxt_state = ST_GAP;
          nxt_cnt   = GAP_T - 4'h1;
        end
      end
      ST_GAP:
      begin
        if (expire)
        begin
          nxt_state = ST_CMD;
          nxt_cnt   = CMD_T - 4'h1;
        end
      end
      ST_CMD:
      begin
        // a slave holding ready low stretches the strobe
        if (expire && rdy_sync_ff)
        begin
          nxt_state = ST_HOLD;
          nxt_cnt   = HOLD_T - 4'h1;
        end
      end
      ST_HOLD:
      begin
        // addresses stay put; next latch comes only after hold and setup
        if (expire)
        begin
          nxt_state = ST_IDLE;
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
        nxt_cnt   = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 4'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // ****************************************************************
  // cycle attributes
  // ****************************************************************
  // loaded only when a request is taken, so they cannot move mid-cycle
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      cyc_io_ff   <= 1'b0;
      cyc_wr_ff   <= 1'b0;
      cyc_low_ff  <= 1'b0;
      cyc_wide_ff <= 1'b0;
    end
    else if (take)
    begin
      cyc_io_ff   <= req_io_i;
      cyc_wr_ff   <= req_write_i;
      cyc_low_ff  <= (req_addr_i[23:20] == LOW_MEG);
      cyc_wide_ff <= req_wide_i;
    end
  end

  // ****************************************************************
  // address pins
  // ****************************************************************
  // held from one take to the next; requests are refused until the hold
  // phase is over, and that is what keeps the trailing address times
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      la_o     <= LA_RST;
      sa_o     <= SA_RST;
      sbhe_n_o <= 1'b1;
    end
    else if (take)
    begin
      la_o     <= req_addr_i[23:17];
      sa_o     <= req_addr_i[19:0];
      sbhe_n_o <= req_sbhe_n_i;
    end
  end

  // ****************************************************************
  // phase decode
  // ****************************************************************
  // only the latched attributes pick the strobe, so a request in flight cannot
  wire [5:0] nxt_strobe = strobe_vec(nxt_state == ST_CMD, cyc_io_ff, cyc_wr_ff, cyc_low_ff);
  wire       nxt_ale_n  = (nxt_state != ST_ALE);
  wire       nxt_ready  = (nxt_state == ST_IDLE);
  wire       nxt_done   = (state_ff == ST_HOLD) && (nxt_state == ST_IDLE);
  wire [5:0] strobe_n;

  // ****************************************************************
  // address latch and handshake
  // ****************************************************************
  // pins follow the next state so each one changes on the edge that starts its phase
  // ready and done rise together, so a held request is taken on the very next edge
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      ale_n_o     <= 1'b1;
      req_ready_o <= 1'b0;
      done_o      <= 1'b0;
    end
    else
    begin
      ale_n_o     <= nxt_ale_n;
      req_ready_o <= nxt_ready;
      done_o      <= nxt_done;
    end
  end

  // ****************************************************************
  // command strobes
  // ****************************************************************
  // one flop per pin, so every strobe leaves a register with no glitch
  // a memory cycle below one megabyte drives the s-strobes as well
  for (genvar g = 0; g < 6; g++)
  begin : g_strobe
    logic pin_n_ff;

    always_ff @(posedge clk_sys_i)
    begin
      if (!rstn_i)
      begin
        pin_n_ff <= 1'b1;
      end
      else
      begin
        pin_n_ff <= ~nxt_strobe[g];
      end
    end

    assign strobe_n[g] = pin_n_ff;
  end : g_strobe

  assign memr_n_o  = strobe_n[5];
  assign memw_n_o  = strobe_n[4];
  assign smemr_n_o = strobe_n[3];
  assign smemw_n_o = strobe_n[2];
  assign ior_n_o   = strobe_n[1];
  assign iow_n_o   = strobe_n[0];

endmodule : isa_master_cycle_timing
`default_nettype wire

// [testbench/isa_timing_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// bus pin spacing in system clocks, T = 5 clocks
// ****************************************************************
module isa_timing_checker (
  input wire logic        clk_sys_i,
  input wire logic        rstn_i,
  input wire logic        ale_n_o,
  input wire logic        sbhe_n_o,
  input wire logic [6:0]  la_o,
  input wire logic [19:0] sa_o,
  input wire logic        memr_n_o,
  input wire logic        memw_n_o,
  input wire logic        smemr_n_o,
  input wire logic        smemw_n_o,
  input wire logic        ior_n_o,
  input wire logic        iow_n_o
);
  wire logic mem_n = memr_n_o & memw_n_o;
  wire logic cmd_n = mem_n & smemr_n_o & smemw_n_o & ior_n_o & iow_n_o;
  logic [7:0] a_age, l_age, c_age, i_age, r_age;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  // ages saturate high out of reset, so no bound trips before the first cycle
  function automatic logic [7:0] nx(input logic rst, input logic ev, input logic [7:0] v);
    return rst ? 8'hFF : ev ? 8'h01 : v + 8'(v != 8'hFF);
  endfunction : nx
  always_ff @(posedge clk_sys_i)
  begin
    a_age <= nx(!rstn_i, $changed({la_o, sa_o, sbhe_n_o}), a_age);
    l_age <= nx(!rstn_i, $fell(ale_n_o), l_age);
    c_age <= nx(!rstn_i, $fell(cmd_n), c_age);
    i_age <= nx(!rstn_i, $rose(cmd_n), i_age);
    r_age <= nx(!rstn_i, $rose(ale_n_o), r_age);
  end
  chk_la_lead: assert property ($fell(mem_n) |-> a_age >= 8'd25)
    else $error("upper address late before memory strobe");
  chk_sa_ale: assert property ($rose(ale_n_o) |-> a_age >= 8'd5)
    else $error("system address late before latch end");
  chk_sa_lead: assert property ($fell(cmd_n) |-> a_age >= 8'd10)
    else $error("system address late before strobe");
  chk_ale_width: assert property ($fell(ale_n_o) |-> (!ale_n_o) [*5])
    else $error("latch pulse too short");
  chk_ale_lead: assert property ($fell(cmd_n) |-> l_age >= 8'd10)
    else $error("latch too close to strobe");
  chk_la_hold: assert property ($changed(la_o) |-> l_age >= 8'd75 && c_age >= 8'd65)
    else $error("upper address changed too early");
  chk_la_after_ale: assert property ($changed(la_o) |-> r_age >= 8'd70)
    else $error("upper address changed too soon after latch end");
  chk_mem_end: assert property ($rose(mem_n) |-> l_age >= 8'd55)
    else $error("memory strobe ended too soon after latch");
  chk_cmd_width: assert property ($rose(cmd_n) |-> c_age >= 8'd45)
    else $error("strobe too short");
  chk_sa_hold: assert property ($changed({sa_o, sbhe_n_o}) |-> c_age >= 8'd50)
    else $error("system address changed too early");
  chk_gap_ale: assert property ($fell(ale_n_o) |-> cmd_n && i_age >= 8'd5)
    else $error("latch too soon after strobe end");
  chk_io_space: assert property ($fell(ior_n_o & iow_n_o) |-> c_age >= 8'd60)
    else $error("io strobes too close");
endmodule : isa_timing_checker
`default_nettype wire

// [testbench/isa_slave_model.sv]
`timescale 1ns/1ps
`default_nettype none
module isa_slave_model (
  input wire logic       clk_sys_i,
  input wire logic       cmd_n_i,
  input wire logic [7:0] wait_i,
  output var logic       iochrdy_o
);
  logic [7:0] cnt_ff = 8'h00;
  logic       cmd_q  = 1'b1;
  // ready is driven straight from the count: high whenever no stretch is running
  assign iochrdy_o = (cnt_ff == 8'h00);
  always @(posedge clk_sys_i)
  begin
    if (cmd_q && !cmd_n_i)
      cnt_ff <= wait_i;
    else if (cnt_ff != 8'h00)
      cnt_ff <= cnt_ff - 8'h01;
    cmd_q <= cmd_n_i;
  end
endmodule : isa_slave_model
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct { logic [6:0] la; logic [19:0] sa; logic sb; logic [5:0] st; int w; } note_s;
  logic clk_sys_i = 1'b0, rstn_i = 1'b0, req_valid_i = 1'b0, req_write_i = 1'b0, req_io_i = 1'b0;
  logic req_wide_i = 1'b0, req_sbhe_n_i = 1'b1, req_ready_o, done_o, iochrdy_i, ale_n_o, sbhe_n_o;
  logic [23:0] req_addr_i = 24'h000000;
  logic [7:0]  wait_cyc = 8'h00;
  logic [6:0]  la_o;
  logic [19:0] sa_o;
  logic memr_n_o, memw_n_o, smemr_n_o, smemw_n_o, ior_n_o, iow_n_o;
  logic cmd_q = 1'b1;
  int err_count = 0, n_tests = 0, wid = 0;
  note_s q[$];
  note_s cur;
  wire logic [5:0] strb = {memr_n_o, memw_n_o, smemr_n_o, smemw_n_o, ior_n_o, iow_n_o};
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  isa_master_cycle_timing isa_master_cycle_timing_inst (.clk_sys_i, .rstn_i, .req_valid_i, .req_write_i,
    .req_io_i, .req_wide_i, .req_addr_i, .req_sbhe_n_i, .req_ready_o, .done_o, .iochrdy_i, .ale_n_o, .la_o,
    .sa_o, .sbhe_n_o, .memr_n_o, .memw_n_o, .smemr_n_o, .smemw_n_o, .ior_n_o, .iow_n_o);
  isa_slave_model isa_slave_model_inst (.clk_sys_i, .cmd_n_i(&strb), .wait_i(wait_cyc), .iochrdy_o(iochrdy_i));
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  // m: bit0 io, bit1 write, bit2 wide, bit3 low megabyte; wt stretches the strobe
  task automatic run_cycle(input logic [3:0] m, input logic [7:0] wt);
    note_s n;
    logic [23:0] ad;
    logic lo;
    int k;
    ad = 24'($urandom);
    if (m[3])
      ad[23:20] = 4'h0;
    lo = (ad[23:20] == 4'h0);
    n.la = ad[23:17];
    n.sa = ad[19:0];
    n.sb = 1'($urandom);
    n.st = ~{!m[0] & !m[1], !m[0] & m[1], !m[0] & !m[1] & lo, !m[0] & m[1] & lo, m[0] & !m[1], m[0] & m[1]};
    n.w = (wt > 8'd45) ? int'(wt) : 45;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b1;
    req_io_i <= m[0];
    req_write_i <= m[1];
    req_wide_i <= m[2];
    req_addr_i <= ad;
    req_sbhe_n_i <= n.sb;
    wait_cyc <= wt;
    k = 0;
    do
    begin
      @(negedge clk_sys_i);
      k++;
    end
    while (req_ready_o !== 1'b1 && k < 300);
    if (k >= 300)
    begin
      err_count++;
      complete_run();
    end
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
    q.push_back(n);
    k = 0;
    do
    begin
      @(negedge clk_sys_i);
      k++;
    end
    while (done_o !== 1'b1 && k < 3000);
    if (k >= 3000)
    begin
      err_count++;
      complete_run();
    end
    check("ready at done", 32'h1, {31'h0, req_ready_o});
    check("note consumed", 32'h0, q.size());
    @(negedge clk_sys_i);
    check("done pulse", 32'h0, {31'h0, done_o});
  endtask : run_cycle
  // ****************************************************************
  // watcher: compares each strobe against the oldest note
  // ****************************************************************
  always @(negedge clk_sys_i)
  begin
    if (cmd_q && !(&strb))
    begin
      if (q.size() == 0)
        check("unrequested strobe", 32'h0, 32'h1);
      else
      begin
        cur = q.pop_front();
        check("upper address", {25'h0, cur.la}, {25'h0, la_o});
        check("system address", {12'h0, cur.sa}, {12'h0, sa_o});
        check("byte high", {31'h0, cur.sb}, {31'h0, sbhe_n_o});
        check("strobe set", {26'h0, cur.st}, {26'h0, strb});
        check("busy in cycle", 32'h0, {31'h0, req_ready_o});
      end
      wid = 0;
    end
    if (!(&strb))
      wid++;
    if (!cmd_q && (&strb))
      check("strobe long enough", 32'h1, {31'h0, wid >= cur.w});
    cmd_q = &strb;
  end
  initial
  begin
    void'($urandom(32'hA59FC21E));
    repeat (8) @(posedge clk_sys_i);
    check("pins in reset", 32'hFF, {24'h0, ale_n_o, sbhe_n_o, strb});
    rstn_i <= 1'b1;
    for (int i = 0; i < 16; i++)
      run_cycle(4'(i), (i % 5 == 0) ? 8'd120 : 8'd0);
    complete_run();
  end
endmodule : testbench
bind isa_master_cycle_timing isa_timing_checker isa_timing_checker_inst (.clk_sys_i, .rstn_i, .ale_n_o,
  .sbhe_n_o, .la_o, .sa_o, .memr_n_o, .memw_n_o, .smemr_n_o, .smemw_n_o, .ior_n_o, .iow_n_o);
`default_nettype wire
